// ==== verilog/fcwas_defs.vh ====
// constants of the fast acquisition sequencer
// assumes a 40 mhz aclk and an axi4-lite master
`ifndef FCWAS_DEFS_VH
`define FCWAS_DEFS_VH

// ==========================================
// clock and rates
`define FCWAS_CLK_HZ        40000000
`define FCWAS_PLAIN_BURST   5000
`define FCWAS_PLAIN_SUST    3333
`define FCWAS_COLL_BURST    4000
`define FCWAS_COLL_SUST     3333
`define FCWAS_RANGED_RATE   2500
`define FCWAS_MUX_BURST     4000
`define FCWAS_MUX_SUST      3333
`define FCWAS_PULSE_RATE    1650
`define FCWAS_READOUT_RATE  5000
`define FCWAS_FIFO_DEPTH    100000
`define FCWAS_FIFO_AW       17

// ==========================================
// register byte offsets
`define FCWAS_CTRL_OFS      8'h00
`define FCWAS_DELAY_OFS     8'h04
`define FCWAS_TRIG_OFS      8'h08
`define FCWAS_STAT_OFS      8'h0c
`define FCWAS_DATA_OFS      8'h10

// ==========================================
// ctrl fields and reset values
`define FCWAS_CTRL_MODE     2:0
`define FCWAS_CTRL_NRAT     4:3
`define FCWAS_CTRL_EACH     5
`define FCWAS_CTRL_RST      6'h00
`define FCWAS_DELAY_RST     32'h0000_0000

// ==========================================
// status fields
`define FCWAS_STAT_OVF      17
`define FCWAS_STAT_BUSY     18
`define FCWAS_STAT_EMPTY    19

// ==========================================
// modes
`define FCWAS_M_OFF         3'h0
`define FCWAS_M_PLAIN       3'h1
`define FCWAS_M_COLLECT     3'h2
`define FCWAS_M_RANGED      3'h3
`define FCWAS_M_MUX         3'h4
`define FCWAS_M_PULSE       3'h5

// ==========================================
// axi responses
`define FCWAS_RESP_OKAY     2'b00
`define FCWAS_RESP_SLVERR   2'b10

`endif

// ==== verilog/fcwas_seq.v ====
// fast acquisition sequencer: triggers, delay, timing, fifo, axi4-lite
// assumes same-clock sample data and a remote flag from instrument logic
`timescale 1ns/1ps
`default_nettype none
`include "fcwas_defs.vh"

module fcwas_seq #(
   parameter integer DEPTH     = `FCWAS_FIFO_DEPTH,
   parameter integer AW        = `FCWAS_FIFO_AW,
   parameter integer HAS_PULSE = 1,
   parameter integer CLK_HZ    = `FCWAS_CLK_HZ,
   parameter integer CYC_PLB   = (CLK_HZ + `FCWAS_PLAIN_BURST - 1) / `FCWAS_PLAIN_BURST,
   parameter integer CYC_PLS   = (CLK_HZ + `FCWAS_PLAIN_SUST - 1) / `FCWAS_PLAIN_SUST,
   parameter integer CYC_COB   = (CLK_HZ + `FCWAS_COLL_BURST - 1) / `FCWAS_COLL_BURST,
   parameter integer CYC_COS   = (CLK_HZ + `FCWAS_COLL_SUST - 1) / `FCWAS_COLL_SUST,
   parameter integer CYC_RNG   = (CLK_HZ + `FCWAS_RANGED_RATE - 1) / `FCWAS_RANGED_RATE,
   parameter integer CYC_MXB   = (CLK_HZ + `FCWAS_MUX_BURST - 1) / `FCWAS_MUX_BURST,
   parameter integer CYC_MXS   = (CLK_HZ + `FCWAS_MUX_SUST - 1) / `FCWAS_MUX_SUST,
   parameter integer CYC_PUL   = (CLK_HZ + `FCWAS_PULSE_RATE - 1) / `FCWAS_PULSE_RATE,
   parameter integer CYC_RD    = CLK_HZ / `FCWAS_READOUT_RATE
) (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // axi4-lite write
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // pins
   input  wire        ext_trig_n,
   output reg         stop_sweep_ff,
   output reg         rcv_ready_ff,
   // receiver front end
   input  wire        remote_mode,
   input  wire [31:0] sample_data,
   output reg  [1:0]  ratio_sel_ff,
   output reg         autorange_ff
);

   // ==========================================
   // state
   localparam [1:0] S_IDLE  = 2'd0;
   localparam [1:0] S_DELAY = 2'd1;
   localparam [1:0] S_ACQ   = 2'd2;

   reg  [1:0]    st_ff;
   reg  [31:0]   cnt_ff;
   reg  [5:0]    ctrl_ff;
   reg  [31:0]   delay_ff;
   reg           ovf_ff;
   reg           host_rd_ff;
   reg           bus_trig_ff;
   reg  [2:0]    trig_sync_ff;
   reg  [31:0]   mem [0:DEPTH-1];
   reg  [AW-1:0] wptr_ff;
   reg  [AW-1:0] rptr_ff;
   reg  [AW:0]   level_ff;
   reg  [31:0]   pace_ff;
   reg           aw_ok_ff;
   reg           w_ok_ff;
   reg  [7:0]    awaddr_ff;
   reg  [31:0]   wdata_ff;
   reg  [3:0]    wstrb_ff;
   reg           rd_pend_ff;
   reg  [7:0]    araddr_ff;

   wire [2:0] mode   = ctrl_ff[`FCWAS_CTRL_MODE];
   wire       pulse_ok = (HAS_PULSE != 0);
   wire       active = remote_mode && (mode != `FCWAS_M_OFF) && (mode <= `FCWAS_M_PULSE)
                       && (mode != `FCWAS_M_PULSE || pulse_ok);
   wire       hshake = active && (mode != `FCWAS_M_PLAIN);
   wire       full   = (level_ff == DEPTH[AW:0]);
   wire       empty  = (level_ff == {(AW+1){1'b0}});
   wire       bus_wr = aw_ok_ff && w_ok_ff && !s_axi_bvalid;
   wire [31:0] lvl_ext = {{(31-AW){1'b0}}, level_ff};

   // ==========================================
   // trigger sources
   // pin falling edge or bus write
   wire pin_trig = trig_sync_ff[2] & ~trig_sync_ff[1];
   wire trig_ok  = active && (st_ff == S_IDLE) && (pin_trig || bus_trig_ff);

   always @(posedge aclk) begin
      if (!aresetn) trig_sync_ff <= 3'b111;
      else trig_sync_ff <= {trig_sync_ff[1:0], ext_trig_n};
   end

   // ==========================================
   // acquisition period per mode
   reg [31:0] period;
   always @* begin
      case (mode)
         `FCWAS_M_PLAIN:   period = host_rd_ff ? CYC_PLS : CYC_PLB;
         `FCWAS_M_COLLECT: period = host_rd_ff ? CYC_COS : CYC_COB;
         `FCWAS_M_RANGED:  period = CYC_RNG;
         `FCWAS_M_MUX:     period = host_rd_ff ? CYC_MXS : CYC_MXB;
         `FCWAS_M_PULSE:   period = CYC_PUL;
         default:          period = CYC_PLB;
      endcase
   end

   // ==========================================
   // sequencer
   wire last_ratio = (ratio_sel_ff == ctrl_ff[`FCWAS_CTRL_NRAT]);
   wire acq_done   = (st_ff == S_ACQ) && (cnt_ff <= 32'd1);
   wire push       = acq_done;
   wire mux_more   = (mode == `FCWAS_M_MUX) && !last_ratio;

   always @(posedge aclk) begin
      if (!aresetn) begin
         st_ff        <= S_IDLE;
         cnt_ff       <= 32'h0000_0000;
         ratio_sel_ff <= 2'b00;
      end else begin
         case (st_ff)
            S_IDLE: begin
               if (!active) begin
                  ratio_sel_ff <= 2'b00;
               end
               if (trig_ok) begin
                  st_ff  <= S_DELAY;
                  cnt_ff <= delay_ff;
               end
            end
            S_DELAY: begin
               if (cnt_ff == 32'h0000_0000) begin
                  st_ff  <= S_ACQ;
                  cnt_ff <= period;
               end else begin
                  cnt_ff <= cnt_ff - 32'd1;
               end
            end
            S_ACQ: begin
               cnt_ff <= cnt_ff - 32'd1;
               if (acq_done) begin
                  ratio_sel_ff <= mux_more ? ratio_sel_ff + 2'd1 : 2'b00;
                  if (mux_more && !ctrl_ff[`FCWAS_CTRL_EACH] && active) begin
                     st_ff  <= S_DELAY;
                     cnt_ff <= delay_ff;
                  end else begin
                     st_ff <= S_IDLE;
                  end
               end
            end
            default: st_ff <= S_IDLE;
         endcase
      end
   end

   // ==========================================
   // handshake and front end outputs
   always @(posedge aclk) begin
      if (!aresetn) begin
         stop_sweep_ff <= 1'b1;
         rcv_ready_ff  <= 1'b1;
         autorange_ff  <= 1'b0;
      end else begin
         stop_sweep_ff <= !(hshake && (trig_ok || (st_ff != S_IDLE && !(acq_done && !
                          (mux_more && !ctrl_ff[`FCWAS_CTRL_EACH])))));
         rcv_ready_ff  <= !(hshake && (trig_ok || (st_ff != S_IDLE && !(acq_done && !
                          (mux_more && !ctrl_ff[`FCWAS_CTRL_EACH])))));
         autorange_ff  <= active && (mode == `FCWAS_M_RANGED);
      end
   end

   // ==========================================
   // fifo
   wire pop;
   wire do_push = push && !full;

   always @(posedge aclk) begin
      if (do_push) mem[wptr_ff] <= sample_data;
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         wptr_ff    <= {AW{1'b0}};
         rptr_ff    <= {AW{1'b0}};
         level_ff   <= {(AW+1){1'b0}};
         ovf_ff     <= 1'b0;
         host_rd_ff <= 1'b0;
      end else begin
         if (do_push) wptr_ff <= (wptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wptr_ff + 1'b1;
         if (pop) rptr_ff <= (rptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rptr_ff + 1'b1;
         if (do_push && !pop) level_ff <= level_ff + 1'b1;
         else if (pop && !do_push) level_ff <= level_ff - 1'b1;
         if (push && full) begin
            ovf_ff <= 1'b1;
         end else if (bus_wr && awaddr_ff == `FCWAS_STAT_OFS
                      && wstrb_ff[2] && wdata_ff[`FCWAS_STAT_OVF]) begin
            ovf_ff <= 1'b0;
         end
         if (pop) host_rd_ff <= 1'b1;
         else if (st_ff == S_IDLE && !trig_ok) host_rd_ff <= 1'b0;
      end
   end

   // ==========================================
   // axi4-lite write channel
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `FCWAS_RESP_OKAY;
         aw_ok_ff      <= 1'b0;
         w_ok_ff       <= 1'b0;
         awaddr_ff     <= 8'h00;
         wdata_ff      <= 32'h0000_0000;
         wstrb_ff      <= 4'h0;
         ctrl_ff       <= `FCWAS_CTRL_RST;
         delay_ff      <= `FCWAS_DELAY_RST;
         bus_trig_ff   <= 1'b0;
      end else begin
         bus_trig_ff <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_ff     <= s_axi_awaddr;
            aw_ok_ff      <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_ff     <= s_axi_wdata;
            wstrb_ff     <= s_axi_wstrb;
            w_ok_ff      <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (bus_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `FCWAS_RESP_OKAY;
            case (awaddr_ff)
               `FCWAS_CTRL_OFS: begin
                  if (wstrb_ff[0]) begin
                     ctrl_ff <= wdata_ff[5:0];
                  end
               end
               `FCWAS_DELAY_OFS: begin
                  if (wstrb_ff[0]) delay_ff[7:0]   <= wdata_ff[7:0];
                  if (wstrb_ff[1]) delay_ff[15:8]  <= wdata_ff[15:8];
                  if (wstrb_ff[2]) delay_ff[23:16] <= wdata_ff[23:16];
                  if (wstrb_ff[3]) delay_ff[31:24] <= wdata_ff[31:24];
               end
               `FCWAS_TRIG_OFS: bus_trig_ff <= 1'b1;
               `FCWAS_STAT_OFS: s_axi_bresp <= `FCWAS_RESP_OKAY;
               default:         s_axi_bresp <= `FCWAS_RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            aw_ok_ff      <= 1'b0;
            w_ok_ff       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ==========================================
   // axi4-lite read channel
   wire data_rd = rd_pend_ff && (araddr_ff == `FCWAS_DATA_OFS);
   wire rd_go   = rd_pend_ff && !s_axi_rvalid && (!data_rd || pace_ff == 32'h0000_0000);
   assign pop   = rd_go && data_rd && !empty;

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `FCWAS_RESP_OKAY;
         rd_pend_ff    <= 1'b0;
         araddr_ff     <= 8'h00;
         pace_ff       <= 32'h0000_0000;
      end else begin
         if (pop) pace_ff <= CYC_RD;
         else if (pace_ff != 32'h0000_0000) pace_ff <= pace_ff - 32'd1;
         if (s_axi_arvalid && s_axi_arready) begin
            araddr_ff     <= s_axi_araddr;
            rd_pend_ff    <= 1'b1;
            s_axi_arready <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `FCWAS_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            case (araddr_ff)
               `FCWAS_CTRL_OFS:  s_axi_rdata <= {26'h0, ctrl_ff};
               `FCWAS_DELAY_OFS: s_axi_rdata <= delay_ff;
               `FCWAS_TRIG_OFS:  s_axi_rdata <= 32'h0000_0000;
               `FCWAS_STAT_OFS:  s_axi_rdata <= {12'h0, empty, (st_ff != S_IDLE), ovf_ff,
                                                 lvl_ext[16:0]};
               `FCWAS_DATA_OFS: begin
                  if (empty) begin
                     s_axi_rresp <= `FCWAS_RESP_SLVERR;
                  end else begin
                     s_axi_rdata <= mem[rptr_ff];
                  end
               end
               default: s_axi_rresp <= `FCWAS_RESP_SLVERR;
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            rd_pend_ff    <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ==== dv/fcwas_assertions.sv ====
// checker for the fast acquisition sequencer
// assumes it is bound to fcwas_seq ports
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checker
module fcwas_chk (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        stop_sweep_ff,
   input wire logic        rcv_ready_ff,
   input wire logic        remote_mode
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence rd_reg;
      s_axi_arvalid && s_axi_arready && s_axi_araddr != 8'h10;
   endsequence
   a_b_stands:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_r_stands:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_wr_answer:
      assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write not answered");
   a_rd_answer:
      assert property (rd_reg |-> ##2 s_axi_rvalid) else $error("read not answered");
   a_ar_closed:
      assert property (rd_taken |=> !s_axi_arready) else $error("read taken twice");
   a_lines_pair:
      assert property (stop_sweep_ff == rcv_ready_ff) else $error("lines differ");
   a_hold_span:
      assert property ($fell(stop_sweep_ff) |=> !stop_sweep_ff[*2]) else $error("low too short");
   a_local_idle:
      assert property (!remote_mode && stop_sweep_ff |=> stop_sweep_ff)
      else $error("measured in local");
endmodule
bind fcwas_seq fcwas_chk u_fcwas_chk (.*);
`default_nettype wire

// ==== dv/fcwas_trig_ctl.sv ====
// switch and trigger controller model
// assumes a pulled-up trigger pin, idle high
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// controller model
module fcwas_trig_ctl #(
   parameter integer SETTLE = 6
) (
   input  wire logic aclk,
   input  wire logic go,
   input  wire logic immediate,
   input  wire logic obey,
   input  wire logic event_n,
   input  wire logic hold_n,
   output wire logic ext_trig_n
);
   int   cnt   = 0;
   int   pw    = 0;
   logic armed = 1'b0;
   assign ext_trig_n = (pw == 0);
   always @(posedge aclk) begin
      if (pw > 0) pw <= pw - 1;
      if (go) begin
         armed <= 1'b1;
         cnt   <= SETTLE;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end else if (armed && (immediate || !event_n) && (hold_n || !obey)) begin
         armed <= 1'b0;
         pw    <= 4;
      end
   end
endmodule
`default_nettype wire

// ==== dv/test_fast_cw_acquisition_sequencer.sv ====
// bench for the fast acquisition sequencer
// assumes fcwas_seq, the controller model and the checker
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fail_count++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
// ==========================================
// bench
module test_fast_cw_acquisition_sequencer;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, remote_mode = 1;
   logic go = 0, imm = 1, obey = 1, ev_n = 1;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, sample_data = 0, st;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [1:0]  r, rmax = 0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire logic ext_trig_n, stop_sweep_ff, rcv_ready_ff, autorange_ff;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp, ratio_sel_ff;
   wire logic [31:0] s_axi_rdata;
   int fail_count = 0, check_count = 0, cyc = 0, low = 0, l0, l1;
   fcwas_seq #(.DEPTH(16), .AW(4), .CLK_HZ(40000)) u_fcwas_seq (.*);
   fcwas_trig_ctl u_fcwas_trig_ctl (.aclk, .go, .immediate(imm), .obey, .event_n(ev_n),
      .hold_n(stop_sweep_ff), .ext_trig_n);
   always #12.5 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc++;
      if (!stop_sweep_ff) low++;
      if (ratio_sel_ff > rmax) rmax <= ratio_sel_ff;
      if (cyc == 60000) begin
         fail_count++;
         wrap_up;
      end
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input [7:0] a, input [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic rd(input [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      st = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task automatic wait_fill(input int n);
      do rd(8'h0c); while (st[16:0] != n);
   endtask
   task automatic pop(input [31:0] e);
      rd(8'h10);
      `CHK(st, e)
   endtask
   task automatic fire;
      go <= 1;
      @(posedge aclk);
      go <= 0;
   endtask
   task automatic t_reset;
      rd(8'h00);
      `CHK(st, 32'h0)
      rd(8'h0c);
      `CHK(st, 32'h0008_0000)
      wr(8'h20, 32'h1);
      `CHK(r, 2'b10)
      rd(8'h10);
      `CHK(r, 2'b10)
      `CHK(st, 32'h0)
   endtask
   task automatic t_plain;
      l0 = low;
      wr(8'h00, 32'h1);
      for (int i = 0; i < 3; i++) begin
         sample_data <= 32'ha0 + i;
         wr(8'h08, 0);
         wait_fill(i + 1);
      end
      `CHK(low - l0, 0)
      l1 = cyc;
      for (int i = 0; i < 3; i++) pop(32'ha0 + i);
      `CHK(cyc - l1 > 16, 1'b1)
   endtask
   task automatic t_ovf;
      for (int i = 0; i < 17; i++) begin
         sample_data <= i;
         wr(8'h08, 0);
         if (i < 16) wait_fill(i + 1);
      end
      do rd(8'h0c); while (!st[17]);
      `CHK(st[16:0], 17'd16)
      wr(8'h0c, 32'h0002_0000);
      rd(8'h0c);
      `CHK(st[17], 1'b0)
      for (int i = 0; i < 16; i++) pop(i);
   endtask
   task automatic t_hand;
      sample_data <= 32'hc0;
      wr(8'h00, 32'h2);
      imm <= 0;
      fire;
      repeat (40) @(posedge aclk);
      rd(8'h0c);
      `CHK(st[16:0], 17'd0)
      l0 = low;
      ev_n <= 0;
      wait_fill(1);
      ev_n <= 1;
      imm <= 1;
      l0 = low - l0;
      wr(8'h04, 32'd20);
      l1 = low;
      fire;
      while (stop_sweep_ff) @(posedge aclk);
      obey <= 0;
      fire;
      wait_fill(2);
      repeat (40) @(posedge aclk);
      obey <= 1;
      `CHK(low - l1 - l0, 20)
      rd(8'h0c);
      `CHK(st[16:0], 17'd2)
      pop(32'hc0);
      pop(32'hc0);
   endtask
   task automatic t_mux;
      sample_data <= 32'hd0;
      wr(8'h00, 32'h1c);
      wr(8'h08, 0);
      wait_fill(4);
      `CHK(rmax, 2'd3)
      wr(8'h00, 32'h3c);
      wr(8'h08, 0);
      wait_fill(5);
      repeat (60) @(posedge aclk);
      rd(8'h0c);
      `CHK(st[16:0], 17'd5)
      for (int i = 0; i < 5; i++) pop(32'hd0);
   endtask
   task automatic t_modes;
      sample_data <= 32'he0;
      wr(8'h00, 32'h3);
      repeat (2) @(posedge aclk);
      `CHK(autorange_ff, 1'b1)
      l0 = low;
      wr(8'h08, 0);
      wait_fill(1);
      wr(8'h00, 32'h5);
      wr(8'h08, 0);
      wait_fill(2);
      `CHK(low - l0 > 60, 1'b1)
      pop(32'he0);
      pop(32'he0);
   endtask
   task automatic t_remote;
      remote_mode <= 0;
      wr(8'h00, 32'h2);
      wr(8'h08, 0);
      repeat (40) @(posedge aclk);
      remote_mode <= 1;
      wr(8'h00, 0);
      wr(8'h08, 0);
      fire;
      repeat (40) @(posedge aclk);
      rd(8'h0c);
      `CHK(st[16:0], 17'd0)
      `CHK(stop_sweep_ff, 1'b1)
   endtask
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      t_reset;
      t_plain;
      t_ovf;
      t_hand;
      t_mux;
      t_modes;
      t_remote;
      wrap_up;
   end
endmodule
`default_nettype wire
